// file: rtl/radio_cmd_level_scheduler.sv
// Two-level radio command scheduler with Wishbone registers and events
//
// Local design decisions: the register offsets and register access over Wishbone.
`default_nettype none
module radio_cmd_level_scheduler
	import radio_sched_pkg::*;
(
	input  wire logic        clk_i,        // System clock
	input  wire logic        rst_i,        // Sync reset, active high
	input  wire logic        ce_i,         // Clock enable
	input  wire logic        wb_cyc_i,     // Wishbone cycle
	input  wire logic        wb_stb_i,     // Wishbone strobe
	input  wire logic        wb_we_i,      // Wishbone write
	input  wire logic [7:0]  wb_adr_i,     // Wishbone byte address
	input  wire logic [3:0]  wb_sel_i,     // Wishbone byte selects
	input  wire logic [31:0] wb_dat_i,     // Wishbone write data
	output logic [31:0]      wb_dat_o,     // Wishbone read data
	output logic             wb_ack_o,     // Wishbone acknowledge
	input  wire logic        trigger_i,    // Start trigger
	input  wire logic        bg_done_i,    // Background engine finished
	input  wire logic        fg_done_i,    // Foreground engine finished
	input  wire logic        tx_sent_i,    // Frame transmitted
	input  wire logic        ack_sent_i,   // Auto ack transmitted
	input  wire logic        rx_no_room_i, // Frame did not fit queue
	input  wire logic        entry_done_i, // Queue entry finished
	input  wire logic        boot_open_i,  // Boot opened access
	input  wire logic        boot_done_i,  // Boot complete
	input  wire logic        int_err_i,    // Internal error seen
	input  wire logic [31:0] timer_i,      // Radio timer
	input  wire logic        sfd_i,        // Delimiter found
	input  wire logic        hdr_valid_i,  // Header byte strobe
	input  wire logic        byte_valid_i, // Body byte strobe
	input  wire logic [7:0]  byte_i,       // Received byte
	input  wire logic        frame_end_i,  // Frame end pulse
	input  wire logic        crc_ok_i,     // Checksum good at end
	input  wire logic [7:0]  rssi_i,       // Signal strength
	input  wire logic [7:0]  corr_i,       // Correlation status
	input  wire logic        src_hit_i,    // Source matched
	input  wire logic [7:0]  src_idx_i,    // Matching source index
	output logic             bg_start_o,   // Start background op
	output logic [3:0]       bg_op_o,      // Background op code
	output logic             bg_stop_o,    // Graceful stop request
	output logic             bg_hold_o,    // Background suspended
	output logic             fg_start_o,   // Start foreground op
	output logic [3:0]       fg_op_o,      // Foreground op code
	output logic [31:0]      tx_ptr_o,     // Transmit buffer pointer
	output logic [7:0]       tx_len_o,     // Transmit buffer length
	output logic             tx_hdr_buf_o, // Header byte in buffer
	output logic             tx_auto_crc_o,// Compute checksum
	output logic [31:0]      event_o,      // Event pulses
	output logic [7:0]       elem_byte_o,  // Queue element byte
	output logic             elem_valid_o  // Queue element strobe
);
	typedef enum logic [2:0] {
		BG_IDLE = 3'b001,
		BG_PEND = 3'b010,
		BG_RUN  = 3'b100
	} bg_state_type;
	typedef enum logic [1:0] {
		FG_IDLE = 2'b01,
		FG_RUN  = 2'b10
	} fg_state_type;
	typedef struct packed {
		logic         ack;
		logic [31:0]  rdata;
		logic         setup;
		logic         sched_err;
		bg_state_type bg_st;
		logic         bg_susp;
		logic [3:0]   bg_op;
		logic         bg_last;
		logic         bg_stop_req;
		logic [15:0]  bg_status;
		fg_state_type fg_st;
		logic [3:0]   fg_op;
		logic         fg_last;
		logic [15:0]  fg_status;
		logic [7:0]   rx_cfg;
		logic [31:0]  time_adj;
		logic [15:0]  tx_cfg;
		logic [31:0]  tx_ptr;
		logic [31:0]  events;
		logic         bg_start;
		logic         fg_start;
		logic         bg_stop;
	} state_type;
	state_type c, n;
	logic       req;
	logic       wr;
	logic [3:0] op;
	logic       last;
	logic       bg_busy;
	logic       fg_busy;
	logic [31:0] wmask;
	assign req = wb_cyc_i & wb_stb_i & ~c.ack;
	assign wr = req & wb_we_i;
	assign op = wb_dat_i[3:0];
	assign last = wb_dat_i[CMD_LAST];
	assign bg_busy = (c.bg_st != BG_IDLE);
	assign fg_busy = (c.fg_st != FG_IDLE);
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mask
			assign wmask[8 * gi +: 8] = {8{wb_sel_i[gi]}};
		end
	endgenerate
	always_comb begin
		n = c;
		n.ack = req;
		n.bg_start = 1'b0;
		n.fg_start = 1'b0;
		n.bg_stop = 1'b0;
		n.events = 32'h0000_0000;
		// ************************************************
		// Register reads
		// ************************************************
		if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				REG_BG_STAT:  n.rdata = {16'h0000, c.bg_status};
				REG_FG_STAT:  n.rdata = {16'h0000, c.fg_status};
				REG_RX_CFG:   n.rdata = {24'h000000, c.rx_cfg};
				REG_TIME_ADJ: n.rdata = c.time_adj;
				REG_TX_CFG:   n.rdata = {16'h0000, c.tx_cfg};
				REG_TX_PTR:   n.rdata = c.tx_ptr;
				REG_FLAGS:    n.rdata = {c.fg_op, c.bg_op, 16'h0000,
					c.bg_susp, c.fg_st, c.bg_st, c.sched_err, c.setup};
				default:      n.rdata = 32'h0000_0000;
			endcase
		end
		// ************************************************
		// Plain configuration writes
		// ************************************************
		if (wr) begin
			unique case (wb_adr_i)
				REG_RX_CFG: if (wb_sel_i[0])
					n.rx_cfg = wb_dat_i[7:0];
				REG_TIME_ADJ:
					n.time_adj = (c.time_adj & ~wmask) | (wb_dat_i & wmask);
				REG_TX_CFG:
					n.tx_cfg = (c.tx_cfg & ~wmask[15:0])
						| (wb_dat_i[15:0] & wmask[15:0]);
				REG_TX_PTR:
					n.tx_ptr = (c.tx_ptr & ~wmask) | (wb_dat_i & wmask);
				REG_FLAGS: if (wb_dat_i[FLG_SCHED])
					n.sched_err = 1'b0;
				default: ;
			endcase
		end
		// ************************************************
		// Engine reports
		// ************************************************
		if (c.bg_st == BG_PEND && trigger_i) begin
			n.bg_st = BG_RUN;
			n.bg_status = ST_ACTIVE;
			n.bg_start = 1'b1;
		end
		if (bg_done_i && c.bg_st == BG_RUN) begin
			n.bg_st = BG_IDLE;
			n.bg_susp = 1'b0;
			n.bg_status = c.bg_stop_req ? ST_STOPPED : ST_DONE_OK;
			n.bg_stop_req = 1'b0;
			n.events[EV_BG_DONE] = 1'b1;
			n.events[EV_BG_LAST] = c.bg_last;
			// Concurrent ops other than TX end when their background reports done
			if (fg_busy && c.fg_op != OP_TX) begin
				n.fg_st = FG_IDLE;
				n.fg_status = ST_BGEND;
				n.events[EV_FG_DONE] = 1'b1;
				n.events[EV_FG_LAST] = c.fg_last;
			end
		end
		if (fg_done_i && fg_busy) begin
			n.fg_st = FG_IDLE;
			n.fg_status = ST_DONE_OK;
			n.events[EV_FG_DONE] = 1'b1;
			n.events[EV_FG_LAST] = c.fg_last;
			if (c.bg_susp) begin
				n.bg_susp = 1'b0;
				n.bg_status = ST_ACTIVE;
			end
		end
		// ************************************************
		// Control register
		// ************************************************
		if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
			if (wb_dat_i[CTRL_SETUP])
				n.setup = 1'b1;
			if (wb_dat_i[CTRL_STOP] && c.bg_st == BG_RUN) begin
				n.bg_stop_req = 1'b1;
				n.bg_stop = 1'b1;
			end
			if (wb_dat_i[CTRL_ABORT] && bg_busy) begin
				n.bg_st = BG_IDLE;
				n.bg_susp = 1'b0;
				n.bg_status = ST_ABORT;
				n.events[EV_BG_DONE] = 1'b1;
				n.events[EV_BG_LAST] = c.bg_last;
			end
		end
		// ************************************************
		// Background submission
		// ************************************************
		if (wr && wb_adr_i == REG_BG_CMD && wb_sel_i[0]) begin
			if (bg_busy || (op == OP_OTHER && fg_busy))
				n.sched_err = 1'b1;
			else if (op == OP_OTHER)
				n.bg_op = op;
			else begin
				n.bg_op = op;
				n.bg_last = last;
				n.bg_stop_req = 1'b0;
				if (!c.setup || (op != OP_RX && op != OP_ED)) begin
					n.bg_status = c.setup ? ST_ERR_PAR : ST_NO_SETUP;
					n.events[EV_BG_DONE] = 1'b1;
					n.events[EV_BG_LAST] = last;
				end else begin
					n.bg_st = BG_PEND;
					n.bg_status = ST_PENDING;
				end
			end
		end
		// ************************************************
		// Foreground submission
		// ************************************************
		if (wr && wb_adr_i == REG_FG_CMD && wb_sel_i[0]) begin
			if (fg_busy || (op == OP_OTHER && bg_busy))
				n.sched_err = 1'b1;
			else if (op != OP_OTHER) begin
				n.fg_op = op;
				n.fg_last = last;
				n.events[EV_FG_DONE] = 1'b1;
				n.events[EV_FG_LAST] = last;
				if (!c.setup)
					n.fg_status = ST_NO_SETUP;
				else if ((op == OP_CSMA && !bg_busy)
					|| (op == OP_RXACK && (!bg_busy || c.bg_op != OP_RX)))
					n.fg_status = ST_WRONG_BG;
				else begin
					unique case (op)
						OP_TX, OP_CSMA, OP_RXACK: begin
							n.fg_st = FG_RUN;
							n.fg_status = ST_ACTIVE;
							n.fg_start = 1'b1;
							n.events[EV_FG_DONE] = 1'b0;
							n.events[EV_FG_LAST] = 1'b0;
							if (op == OP_TX && c.bg_st == BG_RUN) begin
								n.bg_susp = 1'b1;
								n.bg_status = ST_SUSP;
							end
						end
						OP_ABG: begin
							n.fg_status = ST_DONE_OK;
							if (bg_busy) begin
								n.bg_st = BG_IDLE;
								n.bg_status = ST_ABORT;
								n.events[EV_BG_DONE] = 1'b1;
								n.events[EV_BG_LAST] = c.bg_last;
							end
						end
						OP_MOD:  n.fg_status = ST_DONE_OK;
						default: n.fg_status = ST_ERR_PAR;
					endcase
				end
			end
		end
		// ************************************************
		// Radio and boot events
		// ************************************************
		n.events[EV_TX_DONE] = tx_sent_i;
		n.events[EV_TX_ACK] = ack_sent_i;
		n.events[EV_RX_OK] = frame_end_i & crc_ok_i;
		n.events[EV_RX_BAD] = frame_end_i & ~crc_ok_i;
		n.events[EV_RX_IGN] = frame_end_i & corr_i[CORR_IGNORE];
		n.events[EV_RX_FULL] = rx_no_room_i;
		n.events[EV_ENTRY] = entry_done_i;
		n.events[EV_BOOT_OPEN] = boot_open_i;
		n.events[EV_BOOT_DONE] = boot_done_i;
		n.events[EV_INT_ERR] = int_err_i;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			c <= '{bg_st: BG_IDLE, fg_st: FG_IDLE, default: '0};
		else if (ce_i)
			c <= n;
	end
	// ************************************************
	// Receive element formatting
	// ************************************************
	rx_element_packer u_packer (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.ce_i         (ce_i),
		.cfg_i        (c.rx_cfg),
		.offset_i     (c.time_adj),
		.timer_i      (timer_i),
		.sfd_i        (sfd_i),
		.hdr_valid_i  (hdr_valid_i),
		.byte_valid_i (byte_valid_i),
		.byte_i       (byte_i),
		.frame_end_i  (frame_end_i),
		.rssi_i       (rssi_i),
		.corr_i       (corr_i),
		.src_hit_i    (src_hit_i),
		.src_idx_i    (src_idx_i),
		.elem_byte_o  (elem_byte_o),
		.elem_valid_o (elem_valid_o)
	);
	assign wb_dat_o = c.rdata;
	assign wb_ack_o = c.ack;
	assign bg_start_o = c.bg_start;
	assign bg_op_o = c.bg_op;
	assign bg_stop_o = c.bg_stop;
	assign bg_hold_o = c.bg_susp;
	assign fg_start_o = c.fg_start;
	assign fg_op_o = c.fg_op;
	assign tx_ptr_o = c.tx_ptr;
	assign tx_len_o = c.tx_cfg[TXC_LEN_LO +: 8];
	assign tx_hdr_buf_o = c.tx_cfg[TXC_HDR];
	// Host-supplied checksum replaces the generated one
	assign tx_auto_crc_o = ~c.tx_cfg[TXC_CRC];
	assign event_o = c.events;
endmodule // radio_cmd_level_scheduler
`default_nettype wire

// file: pkg/radio_sched_pkg.sv
// Constants shared by the radio command scheduler and its receive packer
`default_nettype none
package radio_sched_pkg;
	// Wishbone byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_BG_CMD   = 8'h04;
	localparam logic [7:0] REG_FG_CMD   = 8'h08;
	localparam logic [7:0] REG_BG_STAT  = 8'h0C;
	localparam logic [7:0] REG_FG_STAT  = 8'h10;
	localparam logic [7:0] REG_RX_CFG   = 8'h14;
	localparam logic [7:0] REG_TIME_ADJ = 8'h18;
	localparam logic [7:0] REG_TX_CFG   = 8'h1C;
	localparam logic [7:0] REG_FLAGS    = 8'h20;
	localparam logic [7:0] REG_TX_PTR   = 8'h24;
	// Field positions
	localparam int CTRL_SETUP = 0;
	localparam int CTRL_STOP  = 1;
	localparam int CTRL_ABORT = 2;
	localparam int CMD_LAST   = 8;
	localparam int FLG_SETUP  = 0;
	localparam int FLG_SCHED  = 1;
	localparam int RXC_LEN_LO = 0;
	localparam int RXC_HDR    = 2;
	localparam int RXC_CRC    = 3;
	localparam int RXC_RSSI   = 4;
	localparam int RXC_STAT   = 5;
	localparam int RXC_SRC    = 6;
	localparam int RXC_TIME   = 7;
	localparam int TXC_HDR    = 0;
	localparam int TXC_CRC    = 1;
	localparam int TXC_LEN_LO = 8;
	localparam int CORR_IGNORE = 6;
	// Event line numbers
	localparam int EV_BG_DONE   = 0;
	localparam int EV_BG_LAST   = 1;
	localparam int EV_FG_DONE   = 2;
	localparam int EV_FG_LAST   = 3;
	localparam int EV_TX_DONE   = 4;
	localparam int EV_TX_ACK    = 5;
	localparam int EV_RX_OK     = 16;
	localparam int EV_RX_BAD    = 17;
	localparam int EV_RX_IGN    = 18;
	localparam int EV_RX_FULL   = 22;
	localparam int EV_ENTRY     = 23;
	localparam int EV_BOOT_OPEN = 29;
	localparam int EV_BOOT_DONE = 30;
	localparam int EV_INT_ERR   = 31;
	// Status codes
	localparam logic [15:0] ST_IDLE     = 16'h0000;
	localparam logic [15:0] ST_PENDING  = 16'h0001;
	localparam logic [15:0] ST_ACTIVE   = 16'h0002;
	localparam logic [15:0] ST_SUSP     = 16'h2001;
	localparam logic [15:0] ST_DONE_OK  = 16'h2400;
	localparam logic [15:0] ST_STOPPED  = 16'h2402;
	localparam logic [15:0] ST_BGEND    = 16'h2406;
	localparam logic [15:0] ST_ABORT    = 16'h2407;
	localparam logic [15:0] ST_WRONG_BG = 16'h0806;
	localparam logic [15:0] ST_ERR_PAR  = 16'h2800;
	localparam logic [15:0] ST_NO_SETUP = 16'h2801;
	// Operation codes
	localparam logic [3:0] OP_NONE  = 4'h0;
	localparam logic [3:0] OP_RX    = 4'h1;
	localparam logic [3:0] OP_ED    = 4'h2;
	localparam logic [3:0] OP_TX    = 4'h3;
	localparam logic [3:0] OP_CSMA  = 4'h4;
	localparam logic [3:0] OP_RXACK = 4'h5;
	localparam logic [3:0] OP_ABG   = 4'h6;
	localparam logic [3:0] OP_MOD   = 4'h7;
	localparam logic [3:0] OP_OTHER = 4'h9;
	localparam logic [7:0] SRC_NONE = 8'hFF;
	localparam int         FCS_LEN  = 2;
	localparam int         TS_LEN   = 4;
endpackage
`default_nettype wire

// file: rtl/rx_element_packer.sv
// Receive queue element formatter: length, header, body, trailer fields
`default_nettype none
module rx_element_packer
	import radio_sched_pkg::*;
(
	input  wire logic        clk_i,       // System clock
	input  wire logic        rst_i,       // Sync reset
	input  wire logic        ce_i,        // Clock enable
	input  wire logic [7:0]  cfg_i,       // Receive format config
	input  wire logic [31:0] offset_i,    // Capture time offset
	input  wire logic [31:0] timer_i,     // Radio timer
	input  wire logic        sfd_i,       // Delimiter found pulse
	input  wire logic        hdr_valid_i, // Header byte strobe
	input  wire logic        byte_valid_i,// Body byte strobe
	input  wire logic [7:0]  byte_i,      // Received byte
	input  wire logic        frame_end_i, // Frame end pulse
	input  wire logic [7:0]  rssi_i,      // Signal strength
	input  wire logic [7:0]  corr_i,      // Correlation/checksum status
	input  wire logic        src_hit_i,   // Source entry matched
	input  wire logic [7:0]  src_idx_i,   // First matching entry
	output logic [7:0]       elem_byte_o, // Element byte
	output logic             elem_valid_o // Element byte strobe
);
	typedef enum logic [6:0] {
		PK_IDLE = 7'b0000001,
		PK_LEN0 = 7'b0000010,
		PK_LEN1 = 7'b0000100,
		PK_HDR  = 7'b0001000,
		PK_BODY = 7'b0010000,
		PK_WAIT = 7'b0100000,
		PK_TAIL = 7'b1000000
	} pk_state_type;
	typedef struct packed {
		pk_state_type st;
		logic [7:0]   hdr;
		logic [7:0]   len;
		logic [6:0]   rem;
		logic [2:0]   idx;
		logic [31:0]  stamp;
		logic [7:0]   rssi;
		logic [7:0]   corr;
		logic [7:0]   src;
		logic [7:0]   ob;
		logic         ov;
	} pk_type;
	pk_type c, n;
	logic [7:0] tail_len;
	assign tail_len = {7'h00, cfg_i[RXC_RSSI]} + {7'h00, cfg_i[RXC_STAT]}
		+ {7'h00, cfg_i[RXC_SRC]} + (cfg_i[RXC_TIME] ? 8'h04 : 8'h00);
	always_comb begin
		n = c;
		n.ov = 1'b0;
		if (sfd_i)
			n.stamp = timer_i - offset_i;
		unique case (c.st)
			PK_IDLE: if (hdr_valid_i) begin
				n.hdr = byte_i;
				n.rem = byte_i[6:0];
				n.len = {7'h00, cfg_i[RXC_HDR]} + {1'b0, byte_i[6:0]}
					- (cfg_i[RXC_CRC] ? 8'h00 : 8'h02) + tail_len;
				n.st = (cfg_i[RXC_LEN_LO +: 2] != 2'd0) ? PK_LEN0 : PK_HDR;
			end
			PK_LEN0: begin
				n.ob = c.len;
				n.ov = 1'b1;
				n.st = (cfg_i[RXC_LEN_LO +: 2] == 2'd2) ? PK_LEN1 : PK_HDR;
			end
			PK_LEN1: begin
				n.ob = 8'h00;
				n.ov = 1'b1;
				n.st = PK_HDR;
			end
			PK_HDR: begin
				n.ob = c.hdr;
				n.ov = cfg_i[RXC_HDR];
				n.st = (c.rem == 7'd0) ? PK_WAIT : PK_BODY;
			end
			PK_BODY: if (byte_valid_i) begin
				n.ob = byte_i;
				// Checksum bytes are the last two of the payload
				n.ov = (c.rem > 7'(FCS_LEN)) || cfg_i[RXC_CRC];
				n.rem = c.rem - 7'd1;
				if (c.rem == 7'd1)
					n.st = PK_WAIT;
			end
			PK_WAIT: if (frame_end_i) begin
				n.rssi = rssi_i;
				n.corr = corr_i;
				n.src = src_hit_i ? src_idx_i : SRC_NONE;
				n.idx = 3'd0;
				n.st = PK_TAIL;
			end
			PK_TAIL: begin
				// Fixed order, absent fields skipped without padding
				unique case (c.idx)
					3'd0: begin
						n.ob = c.rssi;
						n.ov = cfg_i[RXC_RSSI];
					end
					3'd1: begin
						n.ob = c.corr;
						n.ov = cfg_i[RXC_STAT];
					end
					3'd2: begin
						n.ob = c.src;
						n.ov = cfg_i[RXC_SRC];
					end
					default: begin
						// Byte-wise, least significant first
						n.ob = c.stamp[8 * (c.idx - 3'd3) +: 8];
						n.ov = cfg_i[RXC_TIME];
					end
				endcase
				n.idx = c.idx + 3'd1;
				if (c.idx == 3'(2 + TS_LEN))
					n.st = PK_IDLE;
			end
			default: n.st = PK_IDLE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			c <= '{st: PK_IDLE, default: '0};
		else if (ce_i)
			c <= n;
	end
	assign elem_byte_o = c.ob;
	assign elem_valid_o = c.ov;
endmodule // rx_element_packer
`default_nettype wire

// file: sim/sched_checker.sv
// Port assertions for the radio command scheduler
`default_nettype none
module sched_checker
	import radio_sched_pkg::*;
(
	input wire logic        clk_i,       // System clock
	input wire logic        rst_i,       // Sync reset
	input wire logic        ce_i,        // Clock enable
	input wire logic        wb_cyc_i,    // Bus cycle
	input wire logic        wb_stb_i,    // Bus strobe
	input wire logic        wb_ack_o,    // Bus acknowledge
	input wire logic        tx_sent_i,   // Frame sent
	input wire logic        ack_sent_i,  // Auto ack sent
	input wire logic        boot_done_i, // Boot complete
	input wire logic        bg_hold_o,   // Background held
	input wire logic [31:0] event_o      // Event pulses
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
		|=> wb_ack_o) else $error("ack missing");
	a_ack_drop: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack too long");
	a_tx_evt: assert property (ce_i && tx_sent_i |=> event_o[EV_TX_DONE])
		else $error("tx event missing");
	a_ackf_evt: assert property (ce_i && ack_sent_i |=> event_o[EV_TX_ACK])
		else $error("ack event missing");
	a_boot_evt: assert property (ce_i && boot_done_i |=> event_o[30])
		else $error("boot event missing");
	a_fg_pair: assert property (event_o[EV_FG_LAST] |-> event_o[2])
		else $error("fg last without done");
	a_bg_pair: assert property (event_o[EV_BG_LAST] |-> event_o[0])
		else $error("bg last without done");
	a_tx_cause: assert property (event_o[4] |-> $past(tx_sent_i))
		else $error("tx event without cause");
	c_fg_last: cover property (event_o[EV_FG_LAST]);
	c_bg_last: cover property (event_o[EV_BG_LAST]);
	c_hold: cover property (bg_hold_o);
endmodule // sched_checker
bind radio_cmd_level_scheduler sched_checker sched_checker_i (.clk_i,
	.rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_sent_i, .ack_sent_i,
	.boot_done_i, .bg_hold_o, .event_o);
`default_nettype wire

// file: sim/engine_model.sv
// Radio engine stand-in: answers the latest start with a done pulse
`default_nettype none
module engine_model #(parameter int LEN = 40) (
	input  wire logic clk_i,   // System clock
	input  wire logic rst_i,   // Sync reset
	input  wire logic start_i, // Operation launched
	output logic      done_o   // Finished pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// Reload on each launch; a stale run still ends a new one launched while cnt is 1
	always_ff @(posedge clk_i) begin
		done_o <= cnt == 1;
		if (rst_i || start_i)
			cnt <= rst_i ? 0 : LEN;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
endmodule // engine_model
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the radio command scheduler
`default_nettype none
module tb;
	import radio_sched_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, trig = 0;
	logic hv = 0, bv = 0, fe = 0, crc_ok = 1, src_hit = 0;
	logic [3:0] sel = 4'hF;
	logic [6:0] pulse = 0;
	logic [7:0] adr = 0, byte_i = 0, rssi = 0, corr = 0, sidx = 0, b, eb;
	logic [7:0] cfg, h, tlen;
	logic [31:0] wdat = 0, timer = 0, evs = 0, rdat, event_o, rd;
	logic [31:0] adj, ts, d, tptr;
	logic [3:0] bop, fop;
	logic ack, bg_done, fg_done, bg_start, fg_start, bg_hold, ev;
	logic thdr, tcrc, bstop, stp = 0;
	logic [7:0] q[$], body[$], exp_q[$];
	int mismatches = 0, n_compared = 0, ticks = 0, k;
	int line_of[7] = '{4, 5, 22, 23, 29, 30, 31};
	radio_cmd_level_scheduler radio_cmd_level_scheduler_i (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .trigger_i(trig),
		.bg_done_i(bg_done), .fg_done_i(fg_done), .tx_sent_i(pulse[0]),
		.ack_sent_i(pulse[1]), .rx_no_room_i(pulse[2]),
		.entry_done_i(pulse[3]), .boot_open_i(pulse[4]),
		.boot_done_i(pulse[5]), .int_err_i(pulse[6]), .timer_i(timer),
		.sfd_i(hv), .hdr_valid_i(hv), .byte_valid_i(bv), .byte_i(byte_i),
		.frame_end_i(fe), .crc_ok_i(crc_ok), .rssi_i(rssi), .corr_i(corr),
		.src_hit_i(src_hit), .src_idx_i(sidx), .bg_start_o(bg_start),
		.bg_op_o(bop), .bg_stop_o(bstop), .bg_hold_o(bg_hold),
		.fg_start_o(fg_start), .fg_op_o(fop), .tx_ptr_o(tptr),
		.tx_len_o(tlen), .tx_hdr_buf_o(thdr), .tx_auto_crc_o(tcrc),
		.event_o(event_o),
		.elem_byte_o(eb), .elem_valid_o(ev));
	engine_model #(.LEN(300)) bg_engine (.clk_i(clk_i), .rst_i(rst_i),
		.start_i(bg_start), .done_o(bg_done));
	engine_model #(.LEN(40)) fg_engine (.clk_i(clk_i), .rst_i(rst_i),
		.start_i(fg_start), .done_o(fg_done));
	initial forever #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		evs <= evs | event_o;
		stp <= stp | bstop;
		if (ev)
			q.push_back(eb);
		timer <= timer + 1;
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic test_done;
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = rdat;
		{cyc, stb} <= 2'b00;
		@(posedge clk_i);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic clr;
		@(negedge clk_i);
		evs = 0;
		stp = 0;
		q.delete();
		@(posedge clk_i);
	endtask
	task automatic wait_ev(input int n);
		repeat (400) if (evs[n] !== 1'b1) @(posedge clk_i);
	endtask
	task automatic go;
		trig <= 1'b1;
		@(posedge clk_i);
		trig <= 1'b0;
	endtask
	// Element as the host should find it, fields in their fixed order
	function automatic void expect_elem(input logic [7:0] fc,
		input logic [7:0] fh, input logic [31:0] fts);
		logic [7:0] n;
		n = 8'(fh[6:0]) + 8'(fc[RXC_HDR]) + 8'(fc[RXC_RSSI])
			+ 8'(fc[RXC_STAT]) + 8'(fc[RXC_SRC])
			+ 8'(fc[RXC_TIME] ? TS_LEN : 0)
			- 8'(fc[RXC_CRC] ? 0 : FCS_LEN);
		exp_q.delete();
		if (fc[RXC_LEN_LO +: 2] != 2'd0)
			exp_q.push_back(n);
		if (fc[RXC_LEN_LO +: 2] == 2'd2)
			exp_q.push_back(8'h00);
		if (fc[RXC_HDR])
			exp_q.push_back(fh);
		for (int j = 0; j < fh[6:0]; j++)
			if (j < fh[6:0] - FCS_LEN || fc[RXC_CRC])
				exp_q.push_back(body[j]);
		if (fc[RXC_RSSI])
			exp_q.push_back(rssi);
		if (fc[RXC_STAT])
			exp_q.push_back(corr);
		if (fc[RXC_SRC])
			exp_q.push_back(src_hit ? sidx : SRC_NONE);
		if (fc[RXC_TIME])
			for (int j = 0; j < TS_LEN; j++)
				exp_q.push_back(fts[8 * j +: 8]);
	endfunction
	initial begin
		void'($urandom(47946));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		adj = $urandom;
		rchk(REG_BG_STAT, ST_IDLE);
		rchk(8'h3C, 32'h0);
		clr();
		wb(1'b1, REG_BG_CMD, 32'h101);
		rchk(REG_BG_STAT, ST_NO_SETUP);
		chk(evs[1:0], 32'h3);
		wb(1'b1, REG_CTRL, 32'h1);
		d = $urandom;
		wb(1'b1, REG_TX_PTR, d);
		wb(1'b1, REG_TX_CFG, d);
		chk(tptr, d);
		chk({thdr, tlen}, {d[TXC_HDR], d[TXC_LEN_LO +: 8]});
		chk(tcrc, !d[TXC_CRC]);
		wb(1'b1, REG_BG_CMD, {28'h0, OP_TX});
		rchk(REG_BG_STAT, ST_ERR_PAR);
		wb(1'b1, REG_FG_CMD, {28'h0, OP_MOD});
		rchk(REG_FG_STAT, ST_DONE_OK);
		clr();
		wb(1'b1, REG_FG_CMD, {28'h010, OP_CSMA});
		rchk(REG_FG_STAT, ST_WRONG_BG);
		chk(evs[3:2], 32'h3);
		wb(1'b1, REG_BG_CMD, {28'h0, OP_ED});
		rchk(REG_BG_STAT, ST_PENDING);
		go();
		rchk(REG_BG_STAT, ST_ACTIVE);
		wb(1'b1, REG_FG_CMD, {28'h0, OP_RXACK});
		rchk(REG_FG_STAT, ST_WRONG_BG);
		wb(1'b1, REG_FG_CMD, {28'h010, OP_ABG});
		rchk(REG_BG_STAT, ST_ABORT);
		wb(1'b1, REG_BG_CMD, {28'h010, OP_RX});
		go();
		chk(bop, OP_RX);
		wb(1'b1, REG_BG_CMD, {28'h0, OP_ED});
		wb(1'b0, REG_FLAGS, 32'h0);
		chk(rd[FLG_SCHED], 1'b1);
		wb(1'b1, REG_FLAGS, 32'h1 << FLG_SCHED);
		wb(1'b0, REG_FLAGS, 32'h0);
		chk(rd[FLG_SCHED], 1'b0);
		wb(1'b1, REG_FG_CMD, {28'h0, OP_OTHER});
		rchk(REG_BG_STAT, ST_ACTIVE);
		wb(1'b0, REG_FLAGS, 32'h0);
		chk(rd[FLG_SCHED], 1'b1);
		wb(1'b1, REG_FLAGS, 32'h1 << FLG_SCHED);
		wb(1'b1, REG_FG_CMD, {28'h010, OP_TX});
		rchk(REG_BG_STAT, ST_SUSP);
		chk(bg_hold, 1'b1);
		chk(fop, OP_TX);
		clr();
		wait_ev(EV_FG_DONE);
		rchk(REG_FG_STAT, ST_DONE_OK);
		rchk(REG_BG_STAT, ST_ACTIVE);
		chk(evs[3:2], 32'h3);
		clr();
		wb(1'b1, REG_CTRL, 32'h3);
		chk(stp, 1'b1);
		wait_ev(EV_BG_LAST);
		rchk(REG_BG_STAT, ST_STOPPED);
		chk(evs[1:0], 32'h3);
		// All fields, none, then random formats
		for (int f = 0; f < 6; f++) begin
			cfg = f == 0 ? 8'hFE : f == 1 ? 8'h00 : 8'($urandom);
			if (cfg[RXC_LEN_LO +: 2] == 2'd3)
				cfg[RXC_LEN_LO] = 1'b0;
			{rssi, corr, sidx} <= 24'($urandom);
			{crc_ok, src_hit} <= 2'($urandom);
			h = {1'($urandom), 7'd3 + 7'($urandom % 8)};
			wb(1'b1, REG_RX_CFG, {24'h0, cfg});
			wb(1'b1, REG_TIME_ADJ, adj);
			clr();
			{hv, byte_i} <= {1'b1, h};
			@(posedge clk_i);
			ts = timer - adj;
			hv <= 1'b0;
			repeat (4) @(posedge clk_i);
			body.delete();
			for (int i = 0; i < h[6:0]; i++) begin
				b = 8'($urandom);
				body.push_back(b);
				{bv, byte_i} <= {1'b1, b};
				@(posedge clk_i);
			end
			{bv, fe} <= 2'b01;
			@(posedge clk_i);
			fe <= 1'b0;
			repeat (12) @(posedge clk_i);
			expect_elem(cfg, h, ts);
			chk(q.size(), exp_q.size());
			for (int j = 0; j < exp_q.size(); j++)
				chk(q[j], exp_q[j]);
			chk(evs[EV_RX_OK], crc_ok);
			chk(evs[EV_RX_BAD], !crc_ok);
			chk(evs[EV_RX_IGN], corr[CORR_IGNORE]);
		end
		for (int i = 0; i < 16; i++) begin
			k = i < 7 ? i : $urandom % 7;
			clr();
			pulse <= 7'h01 << k;
			@(posedge clk_i);
			pulse <= 7'h00;
			repeat (3) @(posedge clk_i);
			chk(evs, 32'h1 << line_of[k]);
		end
		test_done();
	end
endmodule // tb
`default_nettype wire
